/* File: common/fan_pwm_pkg.sv */
// Types shared by the fan drive block
// Assumes fan_pwm_regs.svh supplies the numeric constants
package fan_pwm_pkg;

  // Tachometer count divisor codes
  typedef enum logic [1:0]
  {
    TACH_DIV_4 = 2'b00,
    TACH_DIV_2 = 2'b01,
    TACH_DIV_1 = 2'b10,
    TACH_DIV_8 = 2'b11
  } tach_div_t;

  typedef logic [5:0]  duty_t;
  typedef logic [15:0] step_reload_t;

endpackage

/* File: common/fan_pwm_regs.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes an 8-bit register port and a 25 MHz system clock
`ifndef FAN_PWM_REGS_SVH
`define FAN_PWM_REGS_SVH

// Register offsets
`define FAN_A_DRIVE_ADDR      8'h56
`define FAN_B_DRIVE_ADDR      8'h57
`define FAN_CLOCK_CONFIG_ADDR 8'h58
`define FAN_A_PHASE_ADDR      8'h68
`define FAN_B_PHASE_ADDR      8'h69

// Reset values
`define FAN_A_DRIVE_RESET      8'h00
`define FAN_B_DRIVE_RESET      8'h00
`define FAN_CLOCK_CONFIG_RESET 8'h50

// Drive register fields
`define DRIVE_FORCE_BIT  0
`define DRIVE_DUTY_LSB   1
`define DRIVE_DUTY_MSB   6
`define DRIVE_CLKSEL_BIT 7

// Clock config fields
`define CFG_SRC_A_BIT  0
`define CFG_SRC_B_BIT  1
`define CFG_MULT_A_BIT 2
`define CFG_MULT_B_BIT 3
`define CFG_DIV_A_LSB  4
`define CFG_DIV_A_MSB  5
`define CFG_DIV_B_LSB  6
`define CFG_DIV_B_MSB  7

// Timing: clock period and step times of the duty counter, in ns
`define CLK_PERIOD_NS  40
`define STEP_NS_SEL0   512000
`define STEP_NS_SEL1   256000
`define STEP_NS_SEL2   128000
`define STEP_NS_SEL3   16000
`define TACH_BASE_NS   31240

// Cycle counts derived from the times above (every time divides exactly)
`define STEP_CYC_SEL0  (`STEP_NS_SEL0 / `CLK_PERIOD_NS)
`define STEP_CYC_SEL1  (`STEP_NS_SEL1 / `CLK_PERIOD_NS)
`define STEP_CYC_SEL2  (`STEP_NS_SEL2 / `CLK_PERIOD_NS)
`define STEP_CYC_SEL3  (`STEP_NS_SEL3 / `CLK_PERIOD_NS)
`define TACH_BASE_CYC  (`TACH_BASE_NS / `CLK_PERIOD_NS)

`endif

/* File: rtl/fan_pwm_channel.sv */
// One fan pulse generator: step divider, 6-bit period counter, output
// Assumes step_reload is at least 1 and comes from the same clock
`timescale 1ns/1ps
`include "fan_pwm_regs.svh"

module fan_pwm_channel
  import fan_pwm_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire step_reload_t step_reload,
  input  wire logic         force_high,
  input  wire duty_t        duty,
  output logic              pwm_out,
  output duty_t             phase
);

  step_reload_t div_cnt;
  step_reload_t next_div_cnt;
  logic         step_tick;

  // A step falls due when the divider reaches its last count; the >=
  // keeps a shortened reload from stalling the divider
  assign step_tick    = (div_cnt >= (step_reload - 16'h0001));
  assign next_div_cnt = step_tick ? 16'h0000 : div_cnt + 16'h0001;

  // Step divider
  always_ff @(posedge clk)
  begin
    if (reset)
      div_cnt <= 16'h0000;
    else
      div_cnt <= next_div_cnt;
  end

  // Free-running period counter, 64 steps per period
  always_ff @(posedge clk)
  begin
    if (reset)
      phase <= 6'h00;
    else if (step_tick)
      phase <= phase + 6'h01;
  end

  // Output high while forced, or while the phase is below the duty
  always_ff @(posedge clk)
  begin
    if (reset)
      pwm_out <= 1'b0;
    else
      pwm_out <= force_high | (phase < duty);
  end

endmodule

/* File: rtl/fan_pwm_clock_control.sv */
// Two-channel fan drive: registers, base frequency selection and
// tachometer count clock enables
// Assumes a single 25 MHz clock, synchronous reset on standby power,
// and a register master on the same clock
//
// Functional notes
// - Fan B drive bit 0 forces output high; else duty field rules.
// - Duty counts 64ths high; zero is low, all ones is 63 of 64.
// - Fan B drive bit 7 with fan B source and multiplier sets its rate.
// - Fan A clock select with its source and multiplier sets its rate.
// - Config bit 0 selects fan A clock source.
// - Config bit 1 selects fan B clock source.
// - Config bit 2 doubles fan A output frequency.
// - Config bit 3 doubles fan B output frequency.
// - Config bits 5:4 set fan A tach divisor; 00 four, 11 eight.
// - Config bits 7:6 set fan B tach divisor; reset is two.
// - Fan A drive has force bit 0 and duty bits 6:1 likewise.
`timescale 1ns/1ps
`include "fan_pwm_regs.svh"

module fan_pwm_clock_control
  import fan_pwm_pkg::*;
#(
  parameter int unsigned STEP_CYC_SEL0 = `STEP_CYC_SEL0,
  parameter int unsigned STEP_CYC_SEL1 = `STEP_CYC_SEL1,
  parameter int unsigned STEP_CYC_SEL2 = `STEP_CYC_SEL2,
  parameter int unsigned STEP_CYC_SEL3 = `STEP_CYC_SEL3
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            fan_a_output,
  output logic            fan_b_output,
  output logic            tach_a_count_tick,
  output logic            tach_b_count_tick
);

  // Register storage
  logic [7:0]   fan_a_drive;
  logic [7:0]   fan_b_drive;
  logic [7:0]   fan_clock_config;

  // Address decode
  logic         hit_a_drive;
  logic         hit_b_drive;
  logic         hit_config;
  logic         hit_a_phase;
  logic         hit_b_phase;
  logic         wr_a_drive;
  logic         wr_b_drive;
  logic         wr_config;
  logic [7:0]   read_mux;

  // Drive fields
  logic         force_a;
  logic         force_b;
  duty_t        duty_a;
  duty_t        duty_b;
  logic         clksel_a;
  logic         clksel_b;

  // Clock config fields
  logic         src_a;
  logic         src_b;
  logic         mult_a;
  logic         mult_b;
  tach_div_t    div_a;
  tach_div_t    div_b;

  // Selected step reloads, the pwm_output_frequency setting per fan
  step_reload_t reload_a;
  step_reload_t reload_b;

  // Channel state
  duty_t        phase_a;
  duty_t        phase_b;

  // Tachometer count clock
  logic [15:0]  tach_base_cnt;
  logic         tach_base_tick;
  logic [2:0]   tach_a_cnt;
  logic [2:0]   tach_b_cnt;
  logic         tach_a_due;
  logic         tach_b_due;
  logic [2:0]   next_tach_a_cnt;
  logic [2:0]   next_tach_b_cnt;

  localparam logic [15:0] TACH_BASE_LAST = 16'(`TACH_BASE_CYC - 1);

  // Base step reload from source select and clock select, halved when
  // the multiplier is on; never falls below one cycle
  function automatic step_reload_t step_reload_of
  (
    input logic src,
    input logic clksel,
    input logic mult
  );
    step_reload_t base;
    base = 16'h0001;
    case ({src, clksel})
      2'b00:   base = 16'(STEP_CYC_SEL0);
      2'b01:   base = 16'(STEP_CYC_SEL1);
      2'b10:   base = 16'(STEP_CYC_SEL2);
      2'b11:   base = 16'(STEP_CYC_SEL3);
      default: base = 16'(STEP_CYC_SEL0);
    endcase
    if (mult)
      base = base >> 1;
    if (base == 16'h0000)
      base = 16'h0001;
    return base;
  endfunction

  // Last count of a tachometer divisor (divisor minus one)
  function automatic logic [2:0] tach_last_of
  (
    input tach_div_t code
  );
    logic [2:0] last;
    last = 3'h0;
    case (code)
      TACH_DIV_4: last = 3'h3;
      TACH_DIV_2: last = 3'h1;
      TACH_DIV_1: last = 3'h0;
      TACH_DIV_8: last = 3'h7;
      default:    last = 3'h1;
    endcase
    return last;
  endfunction

  // Address decode and write strobes
  assign hit_a_drive = (addr == `FAN_A_DRIVE_ADDR);
  assign hit_b_drive = (addr == `FAN_B_DRIVE_ADDR);
  assign hit_config  = (addr == `FAN_CLOCK_CONFIG_ADDR);
  assign hit_a_phase = (addr == `FAN_A_PHASE_ADDR);
  assign hit_b_phase = (addr == `FAN_B_PHASE_ADDR);
  assign wr_a_drive  = wr & hit_a_drive;
  assign wr_b_drive  = wr & hit_b_drive;
  assign wr_config   = wr & hit_config;

  // Read selection; unmapped offsets read zero
  assign read_mux =
    hit_a_drive ? fan_a_drive :
    hit_b_drive ? fan_b_drive :
    hit_config  ? fan_clock_config :
    hit_a_phase ? {fan_a_output, 1'b0, phase_a} :
    hit_b_phase ? {fan_b_output, 1'b0, phase_b} :
    8'h00;

  // Fan A drive register fields
  assign force_a  = fan_a_drive[`DRIVE_FORCE_BIT];
  assign duty_a   = fan_a_drive[`DRIVE_DUTY_MSB:`DRIVE_DUTY_LSB];
  assign clksel_a = fan_a_drive[`DRIVE_CLKSEL_BIT];

  // Fan B drive register fields
  assign force_b  = fan_b_drive[`DRIVE_FORCE_BIT];
  assign duty_b   = fan_b_drive[`DRIVE_DUTY_MSB:`DRIVE_DUTY_LSB];
  assign clksel_b = fan_b_drive[`DRIVE_CLKSEL_BIT];

  // Clock config fields
  assign src_a  = fan_clock_config[`CFG_SRC_A_BIT];
  assign src_b  = fan_clock_config[`CFG_SRC_B_BIT];
  assign mult_a = fan_clock_config[`CFG_MULT_A_BIT];
  assign mult_b = fan_clock_config[`CFG_MULT_B_BIT];
  assign div_a  = tach_div_t'(fan_clock_config[`CFG_DIV_A_MSB:`CFG_DIV_A_LSB]);
  assign div_b  = tach_div_t'(fan_clock_config[`CFG_DIV_B_MSB:`CFG_DIV_B_LSB]);

  // Per-fan step reload from the three select bits
  assign reload_a = step_reload_of(src_a, clksel_a, mult_a);
  assign reload_b = step_reload_of(src_b, clksel_b, mult_b);

  // Fan A drive register
  always_ff @(posedge clk)
  begin
    if (reset)
      fan_a_drive <= `FAN_A_DRIVE_RESET;
    else if (wr_a_drive)
      fan_a_drive <= wdata;
  end

  // Fan B drive register
  always_ff @(posedge clk)
  begin
    if (reset)
      fan_b_drive <= `FAN_B_DRIVE_RESET;
    else if (wr_b_drive)
      fan_b_drive <= wdata;
  end

  // Shared clock config; reset gives divide by two on both fans
  always_ff @(posedge clk)
  begin
    if (reset)
      fan_clock_config <= `FAN_CLOCK_CONFIG_RESET;
    else if (wr_config)
      fan_clock_config <= wdata;
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (rd)
      rdata <= read_mux;
    else
      rdata <= 8'h00;
  end

  // Fan A pulse generator
  fan_pwm_channel u_fan_a
  (
    .clk         (clk),
    .reset       (reset),
    .step_reload (reload_a),
    .force_high  (force_a),
    .duty        (duty_a),
    .pwm_out     (fan_a_output),
    .phase       (phase_a)
  );

  // Fan B pulse generator
  fan_pwm_channel u_fan_b
  (
    .clk         (clk),
    .reset       (reset),
    .step_reload (reload_b),
    .force_high  (force_b),
    .duty        (duty_b),
    .pwm_out     (fan_b_output),
    .phase       (phase_b)
  );

  // Base tachometer counting clock, one pulse per base period
  assign tach_base_tick = (tach_base_cnt >= TACH_BASE_LAST);

  always_ff @(posedge clk)
  begin
    if (reset)
      tach_base_cnt <= 16'h0000;
    else if (tach_base_tick)
      tach_base_cnt <= 16'h0000;
    else
      tach_base_cnt <= tach_base_cnt + 16'h0001;
  end

  // Divisor counters; >= lets a smaller divisor take effect at once
  assign tach_a_due = tach_base_tick & (tach_a_cnt >= tach_last_of(div_a));
  assign tach_b_due = tach_base_tick & (tach_b_cnt >= tach_last_of(div_b));

  assign next_tach_a_cnt = tach_a_due ? 3'h0 :
                           tach_base_tick ? tach_a_cnt + 3'h1 : tach_a_cnt;
  assign next_tach_b_cnt = tach_b_due ? 3'h0 :
                           tach_base_tick ? tach_b_cnt + 3'h1 : tach_b_cnt;

  // Fan A tachometer count enable
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tach_a_cnt        <= 3'h0;
      tach_a_count_tick <= 1'b0;
    end
    else
    begin
      tach_a_cnt        <= next_tach_a_cnt;
      tach_a_count_tick <= tach_a_due;
    end
  end

  // Fan B tachometer count enable
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tach_b_cnt        <= 3'h0;
      tach_b_count_tick <= 1'b0;
    end
    else
    begin
      tach_b_cnt        <= next_tach_b_cnt;
      tach_b_count_tick <= tach_b_due;
    end
  end

endmodule

/* File: sim/fan_monitor.sv */
// Fan side model: measures period and high time of both drive pins
// Assumes the pins are sampled on the system clock
`timescale 1ns/1ps
module fan_monitor
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  pwm,
  output logic      [15:0] period [2],
  output logic      [15:0] high_time [2],
  output logic      [15:0] rises [2]
);
  logic [15:0] cnt [2];
  logic [15:0] hcnt [2];
  logic [1:0]  last;
  // Each rising edge closes one measured period
  always_ff @(posedge clk)
  begin
    last <= reset ? 2'b00 : pwm;
    for (int i = 0; i < 2; i++)
    begin
      if (reset)
      begin
        rises[i] <= 16'h0000;
        cnt[i] <= 16'h0000;
        hcnt[i] <= 16'h0000;
      end
      else if (pwm[i] && !last[i])
      begin
        period[i] <= cnt[i];
        high_time[i] <= hcnt[i];
        rises[i] <= rises[i] + 16'h0001;
        cnt[i] <= 16'h0001;
        hcnt[i] <= 16'h0001;
      end
      else
      begin
        cnt[i] <= cnt[i] + 16'h0001;
        hcnt[i] <= hcnt[i] + 16'(pwm[i]);
      end
    end
  end
endmodule

/* File: sim/fan_pwm_properties.sv */
// Checker of the fan drive block, bound to its top module
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "fan_pwm_regs.svh"
module fan_pwm_props
  import fan_pwm_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       fan_a_output,
  input wire logic       fan_b_output,
  input wire logic       tach_a_count_tick,
  input wire logic       tach_b_count_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0]  a_drv;
  logic [7:0]  b_drv;
  logic [7:0]  cfg;
  logic [15:0] gap_a;
  logic [15:0] gap_b;
  logic        ok_a;
  logic        ok_b;
  wire         cfg_wr = wr && addr == `FAN_CLOCK_CONFIG_ADDR;
  // Tick spacing expected for a divisor code
  function automatic logic [15:0] gap_of(input logic [1:0] c);
    return 16'(`TACH_BASE_CYC) * (c == 2'b00 ? 16'h0004 : c == 2'b11 ? 16'h0008 :
                                  c == 2'b10 ? 16'h0001 : 16'h0002);
  endfunction
  // Shadow registers; spacing counters trusted only after a whole quiet interval
  always_ff @(posedge clk)
  begin
    a_drv <= reset ? 8'h00 : (wr && addr == `FAN_A_DRIVE_ADDR) ? wdata : a_drv;
    b_drv <= reset ? 8'h00 : (wr && addr == `FAN_B_DRIVE_ADDR) ? wdata : b_drv;
    cfg <= reset ? 8'h50 : cfg_wr ? wdata : cfg;
    gap_a <= tach_a_count_tick ? 16'h0001 : gap_a + 16'h0001;
    gap_b <= tach_b_count_tick ? 16'h0001 : gap_b + 16'h0001;
    ok_a <= (reset || cfg_wr) ? 1'b0 : tach_a_count_tick ? 1'b1 : ok_a;
    ok_b <= (reset || cfg_wr) ? 1'b0 : tach_b_count_tick ? 1'b1 : ok_b;
  end
  sequence s_rd(logic [7:0] a);
    rd && addr == a;
  endsequence
  sequence s_held(logic b);
    b [*3];
  endsequence
  property p_force_a;
    s_held(a_drv[0]) |-> fan_a_output;
  endproperty
  property p_force_b;
    s_held(b_drv[0]) |-> fan_b_output;
  endproperty
  property p_zero_a;
    s_held(a_drv[6:0] == 7'h00) |-> !fan_a_output;
  endproperty
  property p_rd_a;
    s_rd(`FAN_A_DRIVE_ADDR) |=> rdata == $past(a_drv);
  endproperty
  property p_rd_b;
    s_rd(`FAN_B_DRIVE_ADDR) |=> rdata == $past(b_drv);
  endproperty
  property p_rd_cfg;
    s_rd(`FAN_CLOCK_CONFIG_ADDR) |=> rdata == $past(cfg);
  endproperty
  property p_gap_a;
    tach_a_count_tick && ok_a |-> gap_a == gap_of(cfg[5:4]);
  endproperty
  property p_gap_b;
    tach_b_count_tick && ok_b |-> gap_b == gap_of(cfg[7:6]);
  endproperty
  property p_pulse_a;
    tach_a_count_tick |=> !tach_a_count_tick [*8];
  endproperty
  a_force_a: assert property (p_force_a) else $error("fan a not forced high");
  a_force_b: assert property (p_force_b) else $error("fan b not forced high");
  a_zero_a: assert property (p_zero_a) else $error("fan a high at duty zero");
  a_rd_a: assert property (p_rd_a) else $error("fan a drive read wrong");
  a_rd_b: assert property (p_rd_b) else $error("fan b drive read wrong");
  a_rd_cfg: assert property (p_rd_cfg) else $error("clock config read wrong");
  a_gap_a: assert property (p_gap_a) else $error("fan a tick spacing wrong");
  a_gap_b: assert property (p_gap_b) else $error("fan b tick spacing wrong");
  a_pulse_a: assert property (p_pulse_a) else $error("fan a tick too long");
endmodule

bind fan_pwm_clock_control fan_pwm_props fan_pwm_props_i (.clk(clk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .fan_a_output(fan_a_output), .fan_b_output(fan_b_output),
  .tach_a_count_tick(tach_a_count_tick), .tach_b_count_tick(tach_b_count_tick));

/* File: sim/testbench.sv */
// Self-checking bench of the fan drive block
// Assumes short step counts 8/4/2/1 cycles and a 25 MHz clock
`timescale 1ns/1ps
`include "fan_pwm_regs.svh"
module testbench;
  import fan_pwm_pkg::*;
  localparam int SEL[4] = '{8, 4, 2, 1};
  localparam int DIV[4] = '{4, 2, 1, 8};
  logic        clk, reset, wr, rd;
  logic [7:0]  addr, wdata, rdata;
  logic        fan_a_output, fan_b_output, tach_a_count_tick, tach_b_count_tick;
  logic [15:0] period [2];
  logic [15:0] high_time [2];
  logic [15:0] rises [2];
  int          n_errors, comparisons, cycles;

  fan_pwm_clock_control #(.STEP_CYC_SEL0(8), .STEP_CYC_SEL1(4), .STEP_CYC_SEL2(2),
    .STEP_CYC_SEL3(1)) fan_pwm_clock_control_i (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fan_a_output(fan_a_output),
    .fan_b_output(fan_b_output), .tach_a_count_tick(tach_a_count_tick),
    .tach_b_count_tick(tach_b_count_tick));
  fan_monitor fan_monitor_i (.clk(clk), .reset(reset), .pwm({fan_b_output, fan_a_output}),
    .period(period), .high_time(high_time), .rises(rises));

  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("read data", 16'(exp), 16'(rdata));
  endtask
  // Read a status register and compare its pin level and spare bit
  task automatic rd_top(input logic [7:0] a, input logic [1:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("status top bits", 16'(exp), 16'(rdata[7:6]));
  endtask
  // Wait for n new rising edges of a fan pin
  task automatic wait_rises(input int f, input int n);
    int s;
    s = rises[f];
    for (int k = 0; k < 4000 && rises[f] < s + n; k++)
      @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    rd_chk(`FAN_A_DRIVE_ADDR, 8'h00);
    rd_chk(`FAN_B_DRIVE_ADDR, 8'h00);
    rd_chk(`FAN_CLOCK_CONFIG_ADDR, 8'h50);
    wr_reg(`FAN_A_DRIVE_ADDR, 8'hA5);
    wr_reg(`FAN_B_DRIVE_ADDR, 8'h5A);
    wr_reg(`FAN_CLOCK_CONFIG_ADDR, 8'hC3);
    wr_reg(8'h60, 8'hFF);
    rd_chk(`FAN_A_DRIVE_ADDR, 8'hA5);
    rd_chk(`FAN_B_DRIVE_ADDR, 8'h5A);
    rd_chk(`FAN_CLOCK_CONFIG_ADDR, 8'hC3);
    rd_chk(8'h60, 8'h00);
  endtask
  // Every source, select and multiplier combination on both fans at half duty
  task automatic t_rate;
    int r;
    for (int f = 0; f < 2; f++)
      for (int c = 0; c < 8; c++)
      begin
        r = c[2] ? ((SEL[c[1:0]] > 1) ? SEL[c[1:0]] / 2 : 1) : SEL[c[1:0]];
        wr_reg(`FAN_CLOCK_CONFIG_ADDR, 8'h50 | (8'(c[1]) << f) | (8'(c[2]) << (2 + f)));
        wr_reg(8'h56 + 8'(f), {c[0], 6'h20, 1'b0});
        wait_rises(f, 3);
        check("period", 16'(64 * r), period[f]);
        check("high time", 16'(32 * r), high_time[f]);
      end
  endtask
  // Duty extremes and forcing, step of 2 cycles
  task automatic t_edges;
    int s;
    wr_reg(`FAN_CLOCK_CONFIG_ADDR, 8'h52);
    wr_reg(`FAN_B_DRIVE_ADDR, 8'h02);
    wait_rises(1, 3);
    check("high time", 16'h0002, high_time[1]);
    wr_reg(`FAN_B_DRIVE_ADDR, 8'h7E);
    wait_rises(1, 3);
    check("high time", 16'h007E, high_time[1]);
    check("period", 16'h0080, period[1]);
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(`FAN_B_DRIVE_ADDR, k ? 8'h7F : 8'h00);
      repeat (4) @(posedge clk);
      s = rises[1];
      repeat (300) @(posedge clk);
      #1 check("fan b level", 16'(k), 16'(fan_b_output));
      check("rises", 16'(s), rises[1]);
      rd_top(`FAN_B_PHASE_ADDR, {k[0], 1'b0});
    end
    wr_reg(`FAN_A_DRIVE_ADDR, 8'h01);
    repeat (4) @(posedge clk);
    #1 check("fan a level", 16'h0001, 16'(fan_a_output));
    rd_top(`FAN_A_PHASE_ADDR, 2'b10);
  endtask
  // Cycles between two count enables of one fan, after any partial interval
  task automatic tick_gap(input int f, output int g);
    for (int n = 0; n < 2; n++)
    begin
      g = 0;
      do
      begin
        @(posedge clk);
        #1 g++;
      end
      while ((f ? tach_b_count_tick : tach_a_count_tick) !== 1'b1 && g < 8000);
    end
  endtask
  // Tick spacing for every divisor code, the two fans on opposite codes
  task automatic t_tach;
    int g;
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(`FAN_CLOCK_CONFIG_ADDR, {2'(3 - k), 2'(k), 4'h0});
      tick_gap(0, g);
      check("tick gap a", 16'(`TACH_BASE_CYC * DIV[k]), 16'(g));
      tick_gap(1, g);
      check("tick gap b", 16'(`TACH_BASE_CYC * DIV[3 - k]), 16'(g));
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_rate();
    t_edges();
    t_tach();
    report_and_stop();
  end
endmodule
